// ### design/gpm_pkg.sv
// Purpose: Shared constants for the port mapping and start-up pin block.
// Assumes: 50 MHz system clock, 32-bit classic Wishbone register bus.
// Notes:   Byte addresses are word aligned; the unlock key value is arbitrary.
package gpm_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int GPM_CLK_MHZ = 50;            // System clock rate
   localparam int GPM_BOOT_TIME_US = 500;      // Boot code duration
   localparam int GPM_BOOT_START_US = 1;       // Boot start after power-up
   localparam int GPM_BOOT_CYCLES = GPM_BOOT_TIME_US * GPM_CLK_MHZ;
   localparam int GPM_START_CYCLES = GPM_BOOT_START_US * GPM_CLK_MHZ;
   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int GPM_NPINS = 8;               // Pins in the port
   localparam int GPM_MAP_W = 3;               // Bits per mapping entry
   localparam int GPM_XIN_PIN = 6;             // Crystal input pin index
   localparam int GPM_CRYSTAL_OUTPUT_PIN_PIN = 7;            // Crystal output pin index
   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] GPM_A_PWD = 8'h00;   // Mapping password register
   localparam logic [7:0] GPM_A_STAT = 8'h04;  // Lock flag, boot busy
   localparam logic [7:0] GPM_A_MAP = 8'h08;   // Pin mapping registers
   localparam logic [7:0] GPM_A_OUT = 8'h0C;   // Output levels
   localparam logic [7:0] GPM_A_DIR = 8'h10;   // Direction, 1 = drive
   localparam logic [7:0] GPM_A_SEL = 8'h14;   // Pin function select
   localparam logic [7:0] GPM_A_IN = 8'h18;    // Pin levels, read only
   localparam logic [7:0] GPM_A_IFG = 8'h1C;   // Sticky edge flags, write 1 clears
   localparam logic [7:0] GPM_A_IE = 8'h20;    // Interrupt mask
   localparam logic [7:0] GPM_A_PWR = 8'h24;   // Deep shutdown control
   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] GPM_MAP_KEY = 16'h2D52; // Arbitrary unlock key
   localparam int GPM_STAT_LOCK_BIT = 0;
   localparam int GPM_STAT_BOOT_BIT = 1;
   localparam int GPM_PWR_SHUT_BIT = 0;
   localparam logic GPM_LOCK_RST = 1'b1;       // Locked out of reset
   localparam logic [31:0] GPM_ZERO = 32'h0000_0000;
endpackage : gpm_pkg

// ### design/gpm_boot_timer.sv
// Purpose: Boot window timer; pins float while it runs.
// Assumes: Restart is a synchronous level from the external reset pin.
// Notes:   Covers the start delay plus the boot code time.
`timescale 1ns/1ns
module gpm_boot_timer #(
   parameter int CYCLES = gpm_pkg::GPM_BOOT_CYCLES + gpm_pkg::GPM_START_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Control
   input wire logic restart_i,
   output logic busy_o
);
   import gpm_pkg::*;
   localparam int CW = $clog2(CYCLES + 1);
   typedef struct packed {
      logic [CW-1:0] cnt;   // Cycles left in the boot window
      logic busy;           // Boot window open
   } gpm_bt_t;
   gpm_bt_t s_r;
   gpm_bt_t s_nxt;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      if (restart_i) begin
         // An external reset mid-boot starts the window again
         s_nxt.cnt = CW'(CYCLES);
         s_nxt.busy = 1'b1;
      end else if (s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - CW'(1);
         s_nxt.busy = (s_r.cnt != CW'(1));
      end
   end

   // Every reset is a brownout reset, so boot always runs after it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r.cnt <= CW'(CYCLES);
         s_r.busy <= 1'b1;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign busy_o = s_r.busy;
endmodule : gpm_boot_timer

// ### design/gpm_port.sv
// Purpose: Port pins with password-locked mapping, boot float, wake logic.
// Assumes: Pin inputs are synchronous to clk_i; rst_i is the brownout reset.
// Notes:   Registers sit on a classic Wishbone slave with one wait state.
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
module gpm_port #(
   parameter int NPINS = gpm_pkg::GPM_NPINS,
   parameter int BOOT_CYCLES = gpm_pkg::GPM_BOOT_CYCLES + gpm_pkg::GPM_START_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Pins and peripheral functions
   input wire logic [NPINS-1:0] gpio_i,
   output logic [NPINS-1:0] gpio_o,
   output logic [NPINS-1:0] gpio_oe_o,
   input wire logic [(1 << gpm_pkg::GPM_MAP_W)-1:0] periph_i,
   // System
   input wire logic ext_rst_i,
   input wire logic dbg_halt_i,
   output logic irq_o,
   output logic shutdown_o,
   output logic wake_o,
   output logic osc_en_o
);
   import gpm_pkg::*;
   localparam int MW = NPINS * GPM_MAP_W;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic ack;                 // Bus answer
      logic [31:0] rdat;         // Read data
      logic locked;              // Mapping lock flag
      logic [MW-1:0] map;        // Pin mapping registers
      logic [NPINS-1:0] pout;    // Output levels
      logic [NPINS-1:0] dir;     // Directions
      logic [NPINS-1:0] fsel;    // Function select
      logic [NPINS-1:0] prev;    // Last pin sample, edge detect
      logic [NPINS-1:0] ifg;     // Sticky edge flags
      logic [NPINS-1:0] ie;      // Interrupt mask
      logic [NPINS-1:0] pin_o;   // Registered pin level
      logic [NPINS-1:0] pin_oe;  // Registered pin enable
      logic shut;                // In deep shutdown
      logic wake;                // Wake pulse
      logic irq;                 // Interrupt level
      logic osc;                 // Oscillator enable
   } gpm_state_t;
   gpm_state_t s_r;
   gpm_state_t s_nxt;

   logic boot_busy;              // Boot window open
   logic [NPINS-1:0] fn_val;     // Mapped peripheral value per pin

   // Byte-lane merge for writes
   function automatic logic [31:0] gpm_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction : gpm_merge

   // ---------------------------------------------------------------
   // Boot window timer
   // ---------------------------------------------------------------
   gpm_boot_timer #(.CYCLES(BOOT_CYCLES)) u_boot (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .restart_i(ext_rst_i),
      .busy_o(boot_busy)
   );

   // ---------------------------------------------------------------
   // Mapping selectors, one per pin
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NPINS; i++) begin : g_map
      // Each pin picks one peripheral line by its mapping entry
      assign fn_val[i] = periph_i[s_r.map[i*GPM_MAP_W +: GPM_MAP_W]];
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic req;
      logic wr;
      logic [NPINS-1:0] ev;
      logic [NPINS-1:0] clr;
      req = 1'b0;
      wr = 1'b0;
      ev = '0;
      clr = '0;
      s_nxt = s_r;
      // One wait state; ack drops the cycle after it was given
      req = cyc_i && stb_i && !s_r.ack;
      wr = req && we_i;
      s_nxt.ack = req;
      s_nxt.rdat = GPM_ZERO;
      // Rising edges on the pins are the port events
      ev = gpio_i & ~s_r.prev;
      s_nxt.prev = gpio_i;
      if (wr) begin
         unique case (adr_i)
            GPM_A_PWD: begin
               // Key unlocks; any other value relocks
               if (sel_i[1:0] == 2'b11) begin
                  // Halting does not hold the flag set
                  s_nxt.locked = (dat_i[15:0] != GPM_MAP_KEY);
               end
            end
            GPM_A_MAP: begin
               // Locked mapping keeps its contents
               if (!s_r.locked) begin
                  s_nxt.map = MW'(gpm_merge(32'(s_r.map), dat_i, sel_i));
               end
            end
            GPM_A_OUT: s_nxt.pout = NPINS'(gpm_merge(32'(s_r.pout), dat_i, sel_i));
            GPM_A_DIR: s_nxt.dir = NPINS'(gpm_merge(32'(s_r.dir), dat_i, sel_i));
            GPM_A_SEL: s_nxt.fsel = NPINS'(gpm_merge(32'(s_r.fsel), dat_i, sel_i));
            GPM_A_IE: s_nxt.ie = NPINS'(gpm_merge(32'(s_r.ie), dat_i, sel_i));
            GPM_A_IFG: begin
               // Write one to clear
               if (sel_i[0]) begin
                  clr = NPINS'(dat_i);
               end
            end
            GPM_A_PWR: begin
               if (sel_i[0] && dat_i[GPM_PWR_SHUT_BIT]) begin
                  s_nxt.shut = 1'b1;
               end
            end
            default: begin
               // Unmapped or read-only: acked, no effect
            end
         endcase
      end else if (req) begin
         unique case (adr_i)
            GPM_A_PWD: s_nxt.rdat = GPM_ZERO;
            GPM_A_STAT: begin
               s_nxt.rdat[GPM_STAT_LOCK_BIT] = s_r.locked;
               s_nxt.rdat[GPM_STAT_BOOT_BIT] = boot_busy;
            end
            GPM_A_MAP: s_nxt.rdat = 32'(s_r.map);
            GPM_A_OUT: s_nxt.rdat = 32'(s_r.pout);
            GPM_A_DIR: s_nxt.rdat = 32'(s_r.dir);
            GPM_A_SEL: s_nxt.rdat = 32'(s_r.fsel);
            GPM_A_IN: s_nxt.rdat = 32'(gpio_i);
            GPM_A_IFG: s_nxt.rdat = 32'(s_r.ifg);
            GPM_A_IE: s_nxt.rdat = 32'(s_r.ie);
            GPM_A_PWR: s_nxt.rdat[GPM_PWR_SHUT_BIT] = s_r.shut;
            default: s_nxt.rdat = GPM_ZERO;
         endcase
      end
      // A new edge beats a clear in the same cycle
      s_nxt.ifg = (s_r.ifg & ~clr) | ev;
      // Pending flag wakes, so an edge near entry is held, not lost
      s_nxt.wake = 1'b0;
      if (s_r.shut && |(s_r.ifg & s_r.ie)) begin
         s_nxt.shut = 1'b0;
         s_nxt.wake = 1'b1;
      end
      s_nxt.irq = |(s_nxt.ifg & s_nxt.ie);
      // Pin drivers; the selected crystal input goes to the oscillator
      s_nxt.osc = s_nxt.fsel[GPM_XIN_PIN];
      for (int i = 0; i < NPINS; i++) begin
         s_nxt.pin_o[i] = s_nxt.fsel[i] ? fn_val[i] : s_nxt.pout[i];
         s_nxt.pin_oe[i] = s_nxt.dir[i];
      end
      // Crystal pins leave the port only by their own select bit
      if (s_nxt.fsel[GPM_XIN_PIN]) begin
         s_nxt.pin_oe[GPM_XIN_PIN] = 1'b0;
      end
      if (s_nxt.fsel[GPM_CRYSTAL_OUTPUT_PIN_PIN]) begin
         s_nxt.pin_oe[GPM_CRYSTAL_OUTPUT_PIN_PIN] = 1'b0;
      end
      // Nothing drives while boot runs, including a restarted boot
      if (boot_busy || ext_rst_i) begin
         s_nxt.pin_oe = '0;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.locked <= GPM_LOCK_RST;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign dat_o = s_r.rdat;
   assign ack_o = s_r.ack;
   assign gpio_o = s_r.pin_o;
   assign gpio_oe_o = s_r.pin_oe;
   assign irq_o = s_r.irq;
   assign shutdown_o = s_r.shut;
   assign wake_o = s_r.wake;
   assign osc_en_o = s_r.osc;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Full-width bus write of the key to the password register
   sequence s_key_wr;
      ce_i && cyc_i && stb_i && !ack_o && we_i && adr_i == GPM_A_PWD
         && sel_i[1:0] == 2'b11 && dat_i[15:0] == GPM_MAP_KEY;
   endsequence
   sequence s_map_wr;
      ce_i && cyc_i && stb_i && !ack_o && we_i && adr_i == GPM_A_MAP;
   endsequence

   a_key_unlocks: assert property (s_key_wr |=> !s_r.locked)
      else $error("valid key did not unlock mapping");
   a_halt_unlock: assert property (s_key_wr and dbg_halt_i |=> !s_r.locked)
      else $error("lock flag stuck while halted");
   a_locked_map: assert property (s_map_wr and s_r.locked |=> $stable(s_r.map))
      else $error("mapping changed while locked");
   a_boot_float: assert property (boot_busy |=> gpio_oe_o == '0)
      else $error("pin driven during boot");
   // First edge out of reset; a check begun while reset is high would be disabled
   a_boot_reset: assert property ($fell(rst_i) |-> boot_busy)
      else $error("boot not run after reset");
   a_restart_float: assert property (ce_i && ext_rst_i |=> boot_busy ##0 gpio_oe_o == '0)
      else $error("pins driven after interrupted boot");
   a_wake_pending: assert property (ce_i && shutdown_o && |(s_r.ifg & s_r.ie)
      |=> wake_o && !shutdown_o)
      else $error("port event did not wake");
   a_crystal_output_pin_port: assert property (ce_i && !boot_busy && !ext_rst_i && s_nxt.dir[GPM_CRYSTAL_OUTPUT_PIN_PIN]
      && !s_nxt.fsel[GPM_CRYSTAL_OUTPUT_PIN_PIN] |=> gpio_oe_o[GPM_CRYSTAL_OUTPUT_PIN_PIN])
      else $error("crystal output port function lost");
   a_ack_once: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   // ---------------------------------------------------------------
   // Lock, flag and enable checks
   // ---------------------------------------------------------------
   // Rising edges seen this cycle; only the checks below read it
   logic [NPINS-1:0] edge_seen;
   assign edge_seen = gpio_i & ~s_r.prev;

   // Full-width write of a wrong value to the password register
   sequence s_bad_key_wr;
      ce_i && cyc_i && stb_i && !ack_o && we_i && adr_i == GPM_A_PWD
         && sel_i[1:0] == 2'b11 && dat_i[15:0] != GPM_MAP_KEY;
   endsequence
   // Mapping write with every lane on while the flag is clear
   sequence s_open_map_wr;
      s_map_wr ##0 !s_r.locked && sel_i == 4'hF;
   endsequence

   a_bad_key_locks: assert property (s_bad_key_wr |=> s_r.locked)
      else $error("wrong key did not lock mapping");
   a_map_lands: assert property (s_open_map_wr |=> s_r.map == MW'($past(dat_i)))
      else $error("unlocked mapping write lost");
   // A clear in the same cycle must never hide a new edge
   a_edge_wins: assert property (ce_i |=> (s_r.ifg & $past(edge_seen)) == $past(edge_seen))
      else $error("pin edge did not set its flag");
   a_wake_pulse: assert property (wake_o |=> !wake_o)
      else $error("wake pulse longer than one cycle");
   a_wake_exit: assert property ($rose(wake_o) |-> $fell(shutdown_o))
      else $error("wake pulse without leaving shutdown");
   // Low enable freezes everything, the boot timer included
   a_ce_freeze: assert property (!ce_i |=> $stable(s_r))
      else $error("state moved while clock enable low");
   a_read_idle: assert property (!ack_o |-> dat_o == GPM_ZERO)
      else $error("read data not zero between answers");
   a_xin_off: assert property (ce_i && s_nxt.fsel[GPM_XIN_PIN]
      |=> !gpio_oe_o[GPM_XIN_PIN] && osc_en_o)
      else $error("crystal input pin still driven");
endmodule : gpm_port

// ### bench/tb_gpm_port.sv
// Purpose: Self-checking bench for the port mapping and start-up pin block.
// Assumes: Classic Wishbone master tasks; shortened boot window of BOOT cycles.
// Notes:   A register mirror in the bench predicts every pin; status reads are checked against fixed values.
`timescale 1ns/1ns
module tb_gpm_port;
   import gpm_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and model state
   // ---------------------------------------------------------------
   localparam int BOOT = 20; // Short boot window keeps the run brief
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q, m;
   logic [7:0] gpio_i = 8'h00, periph_i = 8'h00, gpio_o, gpio_oe_o;
   logic ext_rst_i = 1'b0, dbg_halt_i = 1'b0, irq_o, shutdown_o, wake_o, osc_en_o;
   logic [7:0] out_m, dir_m, sel_m, ie_m, ifg_m; // Mirror of the pin registers
   logic [23:0] map_m; // Mirror of the mapping entries
   int bad_count = 0, cmp_count = 0, seed = 32'h08cc2b1b, wk;
   // ---------------------------------------------------------------
   // Clock and device
   // ---------------------------------------------------------------
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   gpm_port #(.NPINS(8), .BOOT_CYCLES(BOOT)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o),
      .periph_i(periph_i), .ext_rst_i(ext_rst_i), .dbg_halt_i(dbg_halt_i), .irq_o(irq_o),
      .shutdown_o(shutdown_o), .wake_o(wake_o), .osc_en_o(osc_en_o));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Verdict and exit; the only place the run ends
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   // Case inequality so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // One classic cycle; request held until ack is seen at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
         input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) begin
         n++;
         if (n > 50) begin
            chk(32'h0, 32'h1, "bus timeout");
            wrap_up();
         end
         @(posedge clk_i);
      end
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      logic [31:0] r;
      bus(1'b1, a, s, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 4'hF, 32'h0, r);
   endtask : rd
   // Poll the busy bit; a window that never closes is a mismatch
   task automatic wait_boot();
      logic [31:0] r;
      for (int n = 0; n < 40; n++) begin
         rd(GPM_A_STAT, r);
         if (r[GPM_STAT_BOOT_BIT] === 1'b0) begin
            return;
         end
      end
      chk(32'h0, 32'h1, "boot never ends");
      wrap_up();
   endtask : wait_boot
   // Pins from the mirror: each crystal select takes only its own pin off the pad driver
   task automatic chk_pins();
      logic [7:0] eo;
      for (int i = 0; i < 8; i++) begin
         eo[i] = sel_m[i] ? periph_i[map_m[3*i +: 3]] : out_m[i];
      end
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk(32'(gpio_oe_o), 32'(dir_m & ~(sel_m & 8'hC0)), "pin enables");
      chk(32'(gpio_o), 32'(eo), "pin levels");
      chk(32'(irq_o), 32'(|(ifg_m & ie_m)), "irq level");
   endtask : chk_pins
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {out_m, dir_m, sel_m, ie_m, ifg_m, map_m} = '0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      periph_i <= 8'($random(seed));
      // Boot window: registers work, pads stay released
      rd(GPM_A_STAT, q);
      chk(q, 32'h3, "locked and booting");
      dir_m = 8'hFF;
      wr(GPM_A_DIR, 32'(dir_m));
      out_m = 8'($random(seed));
      wr(GPM_A_OUT, 32'(out_m));
      @(negedge clk_i);
      chk(32'(gpio_oe_o), 32'h0, "pads during boot");
      wait_boot();
      chk_pins();
      // Mapping lock: ignored while locked, narrow key write refused
      m = 32'($random(seed)) & 32'h00FF_FFFF;
      wr(GPM_A_MAP, m);
      rd(GPM_A_MAP, q);
      chk(q, 32'h0, "locked map write");
      dbg_halt_i <= 1'b1;
      wr(GPM_A_PWD, 32'(GPM_MAP_KEY), 4'hC);
      rd(GPM_A_STAT, q);
      chk(q, 32'h1, "key without low lanes");
      // Key under a debugger halt still clears the flag
      wr(GPM_A_PWD, 32'(GPM_MAP_KEY));
      rd(GPM_A_STAT, q);
      chk(q, 32'h0, "unlocked while halted");
      dbg_halt_i <= 1'b0;
      map_m = m[23:0];
      wr(GPM_A_MAP, m);
      rd(GPM_A_MAP, q);
      chk(q, m, "map after key");
      wr(GPM_A_PWD, 32'h0);
      rd(GPM_A_STAT, q);
      chk(q, 32'h1, "relocked");
      wr(GPM_A_MAP, ~m);
      rd(GPM_A_MAP, q);
      chk(q, m, "map kept when relocked");
      rd(8'h3C, q);
      chk(q, 32'h0, "unmapped read");
      // Crystal selects act per pin
      sel_m = 8'h41;
      wr(GPM_A_SEL, 32'(sel_m));
      chk_pins();
      chk(32'(osc_en_o), 32'h1, "oscillator on");
      sel_m = 8'hC1;
      wr(GPM_A_SEL, 32'(sel_m));
      chk_pins();
      // Edge flags, mask and write-one clear
      ie_m = 8'($random(seed));
      wr(GPM_A_IE, 32'(ie_m));
      ifg_m = 8'($random(seed)) | 8'h80;
      gpio_i <= ifg_m;
      chk_pins();
      rd(GPM_A_IFG, q);
      chk(q, 32'(ifg_m), "edge flags");
      ie_m = 8'h00;
      wr(GPM_A_IE, 32'h0);
      chk_pins();
      @(posedge clk_i);
      gpio_i <= 8'h00;
      wr(GPM_A_IFG, 32'(ifg_m));
      ifg_m = 8'h00;
      rd(GPM_A_IFG, q);
      chk(q, 32'h0, "flags cleared");
      // Deep shutdown left on an unmasked pin edge, one wake pulse
      ie_m = 8'h01;
      wr(GPM_A_IE, 32'h1);
      wr(GPM_A_PWR, 32'h1);
      rd(GPM_A_PWR, q);
      chk(q, 32'h1, "shutdown entered");
      chk(32'(shutdown_o), 32'h1, "shutdown out");
      @(posedge clk_i);
      gpio_i <= 8'h01;
      wk = 0;
      repeat (8) begin
         @(negedge clk_i);
         wk += (wake_o === 1'b1) ? 1 : 0;
      end
      chk(32'(wk), 32'h1, "wake pulses");
      chk(32'(shutdown_o), 32'h0, "left shutdown");
      ifg_m = 8'h01;
      // Reset pin restarts the window and the pads float again
      @(posedge clk_i);
      ext_rst_i <= 1'b1;
      @(posedge clk_i);
      ext_rst_i <= 1'b0;
      @(negedge clk_i);
      chk(32'(gpio_oe_o), 32'h0, "pads after pin reset");
      rd(GPM_A_STAT, q);
      chk(q, 32'h3, "boot restarted");
      wait_boot();
      chk_pins();
      // Second brownout in mid-run: all cleared, locked, booting
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      {out_m, dir_m, sel_m, ie_m, ifg_m, map_m} = '0;
      @(negedge clk_i);
      chk(32'(gpio_oe_o), 32'h0, "pads after brownout");
      // Enable low for longer than the window: the boot timer must not move
      @(posedge clk_i);
      ce_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      ce_i <= 1'b1;
      rd(GPM_A_STAT, q);
      chk(q, 32'h3, "boot after brownout");
      rd(GPM_A_MAP, q);
      chk(q, 32'h0, "map after brownout");
      wait_boot();
      chk_pins();
      wrap_up();
   end
endmodule : tb_gpm_port
